// *** inc/srap_pkg.sv ***
package srap_pkg;

  localparam int CLK_MHZ = 25;
  localparam int SCLK_MAX_MHZ = 40;
  localparam int CLK_PER_SCLK_MIN = (CLK_MHZ + SCLK_MAX_MHZ - 1) / SCLK_MAX_MHZ;

  localparam logic [4:0] ADDR_SERIAL_PORT_CONFIG = 5'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int CFG_BIDIR_BIT = 7;
  localparam int CFG_LSB_FIRST_BIT = 6;
  localparam int INS_RW_BIT = 7;
  localparam int INS_CNT_HI = 6;
  localparam int INS_CNT_LO = 5;
  localparam int INS_ADDR_HI = 4;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [1:0] CNT_ONE = 2'h0;
  localparam logic [1:0] CNT_TWO = 2'h1;
  localparam logic [1:0] CNT_THREE = 2'h2;
  localparam logic [1:0] CNT_FOUR = 2'h3;

  typedef enum logic [1:0] {
    PH_INSTR = 2'b00,
    PH_DATA = 2'b01,
    PH_DONE = 2'b10
  } srap_phase_e;

  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [7:0] data;
  } srap_wr_s;

  typedef struct packed {
    logic sclk_prev;
    srap_phase_e phase;
    logic [2:0] bit_cnt;
    logic [1:0] bytes_left;
    logic rd;
    logic [4:0] addr;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [7:0] cfg;
    logic out;
    logic oe;
    srap_wr_s wr;
  } srap_state_s;

endpackage : srap_pkg

// *** verilog/srap_sync.sv ***
`timescale 1ns/10ps
module srap_sync
  import srap_pkg::*;
#(
  parameter logic INIT = 1'b0
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic D,
  output logic Q
);

  // The first stage is read only by the second; the filter compares stages two and three.
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic q_r;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      q_r <= INIT;
    end else begin
      s1_r <= D;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_r <= s3_r;
      end
    end
  end

  assign Q = q_r;

endmodule : srap_sync

// *** verilog/srap_port.sv ***
`timescale 1ns/10ps
// Behaviour
// - Writes to the config byte steer bit order and pin mode from the next bit.
// - First eight rising serial clock edges after select falls form the instruction.
// - Select high returns the port to the instruction start regardless of state.
// - A byte cut short by select rising is never written.
// - Count code 00 one, 01 three, 10 two, 11 four bytes.
// - Each written register updates as soon as its byte's last bit arrives.
// - Instruction top bit high means read, low means write.
// - Low five instruction bits give the first address; later ones are generated.
// - Inputs sampled on rising serial clock, outputs launched on falling.
// - With select high both data pins are released.
// - Config bit seven chooses input-only or bidirectional data pin.
// - In bidirectional mode the separate output pin is never driven.
// - Config bit six chooses MSB-first or LSB-first for all bytes.
// - MSB-first multibyte cycles decrement the address.
// - LSB-first multibyte cycles increment the address.
module srap_port
  import srap_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCLK,
  input wire logic CHIP_SELECT_N,
  input wire logic SDIO_I,
  output logic SDIO_O,
  output logic SDIO_OE,
  output logic SERIAL_DATA_OUTPUT_O,
  output logic SERIAL_DATA_OUTPUT_OE,
  output logic [7:0] CONFIG_BYTE,
  output logic REG_WE,
  output logic [4:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA
);

  // The serial clock is oversampled, so it must stay slow against CLK; the bench runs it at 320 ns.
  logic sclk_f;
  logic cs_n_f;
  logic din_f;
  srap_state_s st_r;
  srap_state_s st_nxt;
  logic rise;
  logic fall;
  logic lsb_first;
  logic [7:0] rd_byte;
  logic [7:0] in_byte;

  srap_sync #(.INIT(1'b0)) u_sync_sclk (.CLK(CLK), .RST(RST), .D(SCLK), .Q(sclk_f));
  srap_sync #(.INIT(1'b1)) u_sync_cs (.CLK(CLK), .RST(RST), .D(CHIP_SELECT_N), .Q(cs_n_f));
  srap_sync #(.INIT(1'b0)) u_sync_din (.CLK(CLK), .RST(RST), .D(SDIO_I), .Q(din_f));

  function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic b, input logic lsb);
    shift_in = lsb ? {b, sr[7:1]} : {sr[6:0], b};
  endfunction : shift_in

  function automatic logic pick_bit(input logic [7:0] byt, input logic [2:0] idx, input logic lsb);
    pick_bit = lsb ? byt[idx] : byt[BIT_LAST - idx];
  endfunction : pick_bit

  function automatic logic [1:0] bytes_after_first(input logic [1:0] code);
    logic [1:0] n;
    n = CNT_ONE;
    unique case (code)
      2'b00: n = CNT_ONE;
      2'b01: n = CNT_THREE;
      2'b10: n = CNT_TWO;
      2'b11: n = CNT_FOUR;
    endcase
    bytes_after_first = n;
  endfunction : bytes_after_first

  assign rise = sclk_f & ~st_r.sclk_prev;
  assign fall = ~sclk_f & st_r.sclk_prev;
  assign lsb_first = st_r.cfg[CFG_LSB_FIRST_BIT];
  assign in_byte = shift_in(st_r.shift, din_f, lsb_first);
  // The config byte lives here; the other registers are answered by the device core.
  assign rd_byte = (st_r.addr == ADDR_SERIAL_PORT_CONFIG) ? st_r.cfg : REG_RDATA;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_prev = sclk_f;
    st_nxt.wr.we = 1'b0;
    if (cs_n_f) begin
      st_nxt.phase = PH_INSTR;
      st_nxt.bit_cnt = BIT_FIRST;
      st_nxt.oe = 1'b0;
    end else if (rise) begin
      st_nxt.shift = in_byte;
      st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
      unique case (st_r.phase)
        PH_INSTR: begin
          if (st_r.bit_cnt == BIT_LAST) begin
            st_nxt.phase = PH_DATA;
            st_nxt.rd = in_byte[INS_RW_BIT];
            st_nxt.bytes_left = bytes_after_first(in_byte[INS_CNT_HI:INS_CNT_LO]);
            st_nxt.addr = in_byte[INS_ADDR_HI:0];
          end
        end
        PH_DATA: begin
          if (st_r.bit_cnt == BIT_LAST) begin
            if (!st_r.rd) begin
              if (st_r.addr == ADDR_SERIAL_PORT_CONFIG) begin
                st_nxt.cfg = in_byte;
              end else begin
                st_nxt.wr.we = 1'b1;
                st_nxt.wr.addr = st_r.addr;
                st_nxt.wr.data = in_byte;
              end
            end
            // Uses the bit order in force before this byte; a config change applies to the next step.
            st_nxt.addr = lsb_first ? st_r.addr + 5'h01 : st_r.addr - 5'h01;
            if (st_r.bytes_left == CNT_ONE) begin
              st_nxt.phase = PH_DONE;
            end else begin
              st_nxt.bytes_left = st_r.bytes_left - 2'h1;
            end
          end
        end
        PH_DONE: begin
          st_nxt.bit_cnt = st_r.bit_cnt;
        end
        default: begin
          st_nxt.phase = PH_DONE;
        end
      endcase
    end else if (fall && st_r.rd && st_r.phase == PH_DATA) begin
      st_nxt.oe = 1'b1;
      if (st_r.bit_cnt == BIT_FIRST) begin
        st_nxt.tx = rd_byte;
        st_nxt.out = pick_bit(rd_byte, BIT_FIRST, lsb_first);
      end else begin
        st_nxt.out = pick_bit(st_r.tx, st_r.bit_cnt, lsb_first);
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_r <= '{sclk_prev: 1'b0, phase: PH_INSTR, bit_cnt: BIT_FIRST, bytes_left: CNT_ONE, rd: 1'b0,
                addr: ADDR_SERIAL_PORT_CONFIG, shift: 8'h00, tx: 8'h00, cfg: CFG_RESET, out: 1'b0,
                oe: 1'b0, wr: '{we: 1'b0, addr: 5'h00, data: 8'h00}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign SDIO_O = st_r.out;
  assign SERIAL_DATA_OUTPUT_O = st_r.out;
  assign SDIO_OE = st_r.oe & st_r.cfg[CFG_BIDIR_BIT];
  assign SERIAL_DATA_OUTPUT_OE = st_r.oe & ~st_r.cfg[CFG_BIDIR_BIT];
  assign CONFIG_BYTE = st_r.cfg;
  assign REG_WE = st_r.wr.we;
  assign REG_ADDR = st_r.wr.we ? st_r.wr.addr : st_r.addr;
  assign REG_WDATA = st_r.wr.data;

endmodule : srap_port

// *** test/srap_asserts.sv ***
`timescale 1ns/10ps
module srap_asserts
  import srap_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCLK,
  input wire logic CHIP_SELECT_N,
  input wire logic SDIO_I,
  input wire logic SDIO_O,
  input wire logic SDIO_OE,
  input wire logic SERIAL_DATA_OUTPUT_O,
  input wire logic SERIAL_DATA_OUTPUT_OE,
  input wire logic [7:0] CONFIG_BYTE,
  input wire logic REG_WE,
  input wire logic [4:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Eight cycles of deselect outlast the input filter, so the port must be idle by then.
  sequence cs_idle_s;
    CHIP_SELECT_N [*8];
  endsequence
  pins_released_a: assert property (cs_idle_s |-> !SDIO_OE && !SERIAL_DATA_OUTPUT_OE)
    else $error("data pins driven while deselected");
  sdo_quiet_a: assert property (CONFIG_BYTE[CFG_BIDIR_BIT] |-> !SERIAL_DATA_OUTPUT_OE)
    else $error("output pin driven in bidirectional mode");
  sdio_input_a: assert property (!CONFIG_BYTE[CFG_BIDIR_BIT] |-> !SDIO_OE)
    else $error("data pin driven in input-only mode");
  we_pulse_a: assert property (REG_WE |=> !REG_WE)
    else $error("write strobe longer than one cycle");
  no_abort_we_a: assert property (cs_idle_s |-> !REG_WE)
    else $error("write while deselected");
  cfg_hold_a: assert property (cs_idle_s |-> $stable(CONFIG_BYTE))
    else $error("config changed while deselected");
  read_no_we_a: assert property ((SDIO_OE || SERIAL_DATA_OUTPUT_OE) |-> !REG_WE)
    else $error("write strobe during read");
  cfg_internal_a: assert property (REG_WE |-> REG_ADDR != ADDR_SERIAL_PORT_CONFIG)
    else $error("config address sent to core");
endmodule : srap_asserts
bind srap_port srap_asserts i_srap_asserts (.CLK(CLK), .RST(RST), .SCLK(SCLK), .CHIP_SELECT_N(CHIP_SELECT_N),
  .SDIO_I(SDIO_I), .SDIO_O(SDIO_O), .SDIO_OE(SDIO_OE), .SERIAL_DATA_OUTPUT_O(SERIAL_DATA_OUTPUT_O),
  .SERIAL_DATA_OUTPUT_OE(SERIAL_DATA_OUTPUT_OE), .CONFIG_BYTE(CONFIG_BYTE), .REG_WE(REG_WE),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA));

// *** test/srap_master.sv ***
`timescale 1ns/10ps
module srap_master (
  input wire logic CLK,
  output logic SCLK,
  output logic CHIP_SELECT_N,
  output logic SDIO_I,
  input wire logic MISO
);
  initial begin
    SCLK = 1'b0;
    CHIP_SELECT_N = 1'b1;
    SDIO_I = 1'b0;
  end
  // Read bits are taken late in the high phase, because the input filter delays their launch.
  task automatic shift(input logic [7:0] tx, input logic lsb, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < nb; i++) begin
      SDIO_I <= tx[lsb ? i : 7 - i];
      repeat (4) @(posedge CLK);
      SCLK <= 1'b1;
      repeat (4) @(posedge CLK);
      rx[lsb ? i : 7 - i] = MISO;
      SCLK <= 1'b0;
    end
  endtask : shift
  task automatic xfer(input logic [7:0] ins, input logic lsb, input int n, input int cut,
                      input logic [31:0] wd, output logic [31:0] rd);
    logic [7:0] rx;
    rd = 32'h0;
    CHIP_SELECT_N <= 1'b0;
    repeat (4) @(posedge CLK);
    shift(ins, lsb, 8, rx);
    for (int k = 0; k < n; k++) begin
      shift(wd[8*k+:8], lsb, 8, rx);
      rd[8*k+:8] = rx;
    end
    shift(8'h5a, lsb, cut, rx);
    repeat (8) @(posedge CLK);
    CHIP_SELECT_N <= 1'b1;
    repeat (8) @(posedge CLK);
  endtask : xfer
endmodule : srap_master

// *** test/tb.sv ***
`timescale 1ns/10ps
module tb;
  import srap_pkg::*;
  logic CLK, RST, SCLK, CHIP_SELECT_N, SDIO_I, SDIO_O, SDIO_OE, SERIAL_DATA_OUTPUT_O, SERIAL_DATA_OUTPUT_OE;
  logic REG_WE, miso;
  logic bidir = 1'b0;
  logic [7:0] CONFIG_BYTE, REG_WDATA, REG_RDATA;
  logic [4:0] REG_ADDR;
  logic [12:0] wq[$];
  logic [31:0] rd;
  int n_mismatch = 0;
  int num_checks = 0;
  int nb[4] = '{1, 3, 2, 4};
  function automatic logic [7:0] ex(input logic [4:0] a);
    return {a, 3'h5} ^ 8'h96;
  endfunction : ex
  assign REG_RDATA = ex(REG_ADDR);
  // The master listens only on the pin of the mode it set; an undriven pin shows the inverted bit.
  assign miso = bidir ? (SDIO_OE ? SDIO_O : ~SDIO_O) :
                (SERIAL_DATA_OUTPUT_OE ? SERIAL_DATA_OUTPUT_O : ~SERIAL_DATA_OUTPUT_O);
  srap_port i_srap_port (.CLK(CLK), .RST(RST), .SCLK(SCLK), .CHIP_SELECT_N(CHIP_SELECT_N), .SDIO_I(SDIO_I),
    .SDIO_O(SDIO_O), .SDIO_OE(SDIO_OE), .SERIAL_DATA_OUTPUT_O(SERIAL_DATA_OUTPUT_O),
    .SERIAL_DATA_OUTPUT_OE(SERIAL_DATA_OUTPUT_OE), .CONFIG_BYTE(CONFIG_BYTE), .REG_WE(REG_WE),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA));
  srap_master i_srap_master (.CLK(CLK), .SCLK(SCLK), .CHIP_SELECT_N(CHIP_SELECT_N), .SDIO_I(SDIO_I), .MISO(miso));
  always @(posedge CLK) if (REG_WE) wq.push_back({REG_ADDR, REG_WDATA});
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_wr(input logic [4:0] a, input int n, input logic up, input logic [31:0] dat);
    for (int k = 0; k < n; k++) chk("write", {5'(up ? a + k : a - k), dat[8*k+:8]}, wq[k]);
    chk("count", n, wq.size());
    wq.delete();
  endtask : chk_wr
  task automatic close_out();
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  initial begin
    RST = 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    repeat (4) @(posedge CLK);
    chk("cfg", CFG_RESET, CONFIG_BYTE);
    for (int c = 0; c < 4; c++) begin
      i_srap_master.xfer({1'b0, 2'(c), 5'h0a}, 1'b0, nb[c], 0, 32'hc3a51e69, rd);
      chk_wr(5'h0a, nb[c], 1'b0, 32'hc3a51e69);
    end
    i_srap_master.xfer(8'h03, 1'b0, 0, 7, 32'h0, rd);
    chk("abort", 0, wq.size());
    i_srap_master.xfer(8'ha7, 1'b0, 3, 0, 32'h0, rd);
    chk("read", {8'h00, ex(5'h05), ex(5'h06), ex(5'h07)}, rd);
    chk("release", 2'b00, {SDIO_OE, SERIAL_DATA_OUTPUT_OE});
    i_srap_master.xfer(8'h00, 1'b0, 1, 0, 32'hc0, rd);
    chk("cfg", 8'hc0, CONFIG_BYTE);
    bidir = 1'b1;
    i_srap_master.xfer(8'h50, 1'b1, 2, 0, 32'h7e81, rd);
    chk_wr(5'h10, 2, 1'b1, 32'h7e81);
    i_srap_master.xfer(8'hdd, 1'b1, 2, 0, 32'h0, rd);
    chk("read", {16'h0, ex(5'h1e), ex(5'h1d)}, rd);
    chk("release", 2'b00, {SDIO_OE, SERIAL_DATA_OUTPUT_OE});
    i_srap_master.xfer(8'h80, 1'b1, 1, 0, 32'h0, rd);
    chk("cfg read", 8'hc0, rd);
    close_out();
  end
endmodule : tb
